// ### tb/hibs_host_model.sv
/*
 * host bus model: driver software making i/o and memory cycles.
 * assumes: shares the register clock; every strobe lasts one edge.
 */
`timescale 1ns/1ps
module hibs_host_model (
	// clock
	input wire logic sys_clk_in,
	// bus towards the registers
	output hibs_pkg::hibs_host_req_t host_req_out,
	output logic host_mem_req_out,
	output logic [14:0] host_mem_addr_out
);
	import hibs_pkg::*;
	// idle bus at time zero
	initial begin
		host_req_out = '0;
		host_mem_req_out = 1'b0;
		host_mem_addr_out = '0;
	end
	// one i/o cycle; afterwards both strobes drop to zero and address and data are inverted
	task automatic io_cycle(input logic wr, input logic [5:0] addr, input logic [7:0] data);
		@(posedge sys_clk_in);
		#1;
		host_req_out = {addr, wr, ~wr, data};
		@(posedge sys_clk_in);
		#1;
		host_req_out = {~addr, 1'b0, 1'b0, ~data};
	endtask : io_cycle
	// one common memory cycle
	task automatic mem_cycle(input logic [14:0] addr);
		@(posedge sys_clk_in);
		#1;
		host_mem_req_out = 1'b1;
		host_mem_addr_out = addr;
		@(posedge sys_clk_in);
		#1;
		host_mem_req_out = 1'b0;
		host_mem_addr_out = ~addr;
	endtask : mem_cycle
endmodule : hibs_host_model

// ### tb/host_interrupt_and_bank_select_regs_bench.sv
/*
 * self-checking bench of the host interrupt and bank select registers.
 * assumes: the host model drives the host side; core pins driven here.
 */
`timescale 1ns/1ps
module host_interrupt_and_bank_select_regs_bench;
	import hibs_pkg::*;
	// ****************
	// signals
	// ****************
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	hibs_host_req_t host_req;
	logic mem_req;
	logic [14:0] mem_addr;
	hibs_core_t core = '0;
	logic strap = 1'b0;
	logic [7:0] rdata;
	logic to_core, host_irq, flash_sel, sram_sel, xsel;
	logic [16:0] mem_addr_out;
	logic [4:0] xidx;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	// 40 mhz clock
	always #12.5 sys_clk_in = ~sys_clk_in;
	hibs_host_model host (.sys_clk_in(sys_clk_in), .host_req_out(host_req),
		.host_mem_req_out(mem_req), .host_mem_addr_out(mem_addr));
	hibs_regs dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .host_req_in(host_req),
		.host_rdata_out(rdata), .host_mem_req_in(mem_req), .host_mem_addr_in(mem_addr),
		.core_in(core), .isa_pnp_strap_in(strap), .interrupt_to_core_out(to_core),
		.host_irq_out(host_irq), .flash_sel_out(flash_sel), .sram_sel_out(sram_sel),
		.local_memory_address_out(mem_addr_out), .xcvr_sel_out(xsel), .xcvr_index_out(xidx));
	// ****************
	// tasks
	// ****************
	task check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wr(input logic [5:0] a, input logic [7:0] d);
		host.io_cycle(1'b1, a, d);
	endtask : wr
	// read, data compared in the cycle it stands
	task rd(input logic [5:0] a, input logic [7:0] exp);
		host.io_cycle(1'b0, a, 8'h00);
		check("rdata", {9'h000, rdata}, {9'h000, exp});
	endtask : rd
	// one-cycle pulse on core fields
	task pulse(input hibs_core_t p);
		@(posedge sys_clk_in);
		#1;
		core = core | p;
		@(posedge sys_clk_in);
		#1;
		core = core & ~p;
	endtask : pulse
	task report_and_stop;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	// hang guard
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (20) @(posedge sys_clk_in);
		#1;
		reset_in = 1'b0;
		rd(6'h00, 8'h00);
		rd(6'h01, 8'h00);
		// host interrupt to core, zero write, core clear
		wr(6'h00, 8'h04);
		check("to_core", to_core, 1);
		wr(6'h00, 8'h00);
		check("to_core", to_core, 1);
		rd(6'h00, 8'h04);
		pulse(4'b0100);
		check("to_core", to_core, 0);
		// forwarding gate, sticky status, direct access mirror
		pulse(4'b1000);
		check("host_irq", host_irq, 0);
		wr(6'h00, 8'h02);
		pulse(4'b1000);
		check("host_irq", host_irq, 1);
		wr(6'h00, 8'h02);
		check("host_irq", host_irq, 1);
		core.grant = 1'b1;
		rd(6'h00, 8'h0b);
		wr(6'h00, 8'h0a);
		check("host_irq", host_irq, 0);
		core.grant = 1'b0;
		rd(6'h00, 8'h02);
		// latch flag set by strobe, cleared by zero write
		pulse(4'b0001);
		rd(6'h01, 8'h80);
		wr(6'h01, 8'h40);
		rd(6'h01, 8'h00);
		// memory steering and bank lines
		wr(6'h01, 8'h30);
		host.mem_cycle(15'h1234);
		check("flash", {flash_sel, sram_sel}, 2'b10);
		check("mem_addr", mem_addr_out, 17'h11234);
		wr(6'h01, 8'h08);
		host.mem_cycle(15'h7fff);
		check("sram", {flash_sel, sram_sel}, 2'b01);
		check("mem_addr", mem_addr_out, 17'h0ffff);
		// narrow window with bank bits
		wr(6'h01, 8'h02);
		rd(6'h0d, 8'h00);
		check("xcvr", {xsel, xidx}, 6'h35);
		rd(6'h10, 8'h00);
		check("xcvr_sel", xsel, 0);
		// expanded window
		wr(6'h01, 8'h07);
		rd(6'h01, 8'h07);
		rd(6'h27, 8'h00);
		check("xcvr", {xsel, xidx}, 6'h3f);
		rd(6'h10, 8'h00);
		check("xcvr", {xsel, xidx}, 6'h28);
		rd(6'h28, 8'h00);
		check("xcvr_sel", xsel, 0);
		// isa mode locks window bit at zero
		strap = 1'b1;
		repeat (6) @(posedge sys_clk_in);
		rd(6'h01, 8'h03);
		wr(6'h01, 8'h07);
		rd(6'h01, 8'h03);
		rd(6'h10, 8'h00);
		check("xcvr_sel", xsel, 0);
		// unmapped offset
		wr(6'h02, 8'hff);
		rd(6'h02, 8'h00);
		report_and_stop();
	end
endmodule : host_interrupt_and_bank_select_regs_bench

// ### verilog/hibs_defs.svh
/*
 * offsets, field positions, reset values and window limits of the host
 * interrupt and bank select registers.
 * assumes: included by its bare name from the design file; no timing counts apply.
 */
`ifndef HIBS_DEFS_SVH
`define HIBS_DEFS_SVH

// ********************************************
// register offsets in host i/o space
// ********************************************
`define HIBS_OFS_STATUS 6'h00
`define HIBS_OFS_BANK 6'h01

// ********************************************
// host_interrupt_status_control fields
// ********************************************
`define HIBS_ST_CORE_INT 3
`define HIBS_ST_INT2CORE 2
`define HIBS_ST_FWD_EN 1
`define HIBS_ST_DIRECT 0

// ********************************************
// bank_switching_select fields
// ********************************************
`define HIBS_BK_LATCH 7
`define HIBS_BK_RSVD 6
`define HIBS_BK_FLASH 5
`define HIBS_BK_MBANK_HI 4
`define HIBS_BK_MBANK_LO 3
`define HIBS_BK_EXPWIN 2
`define HIBS_BK_TBANK_HI 1
`define HIBS_BK_TBANK_LO 0

// ********************************************
// reset values and transceiver window limits
// ********************************************
`define HIBS_RST_STATUS 8'h00
`define HIBS_RST_BANK 8'h00
`define HIBS_XWIN_LO 6'h08
`define HIBS_XWIN_NARROW_HI 6'h0f
`define HIBS_XWIN_WIDE_HI 6'h27

`endif

// ### verilog/hibs_pkg.sv
/*
 * types of the host interrupt and bank select registers.
 * assumes: compiled before the design module that imports it.
 */
package hibs_pkg;

	// host i/o request, one strobe per access
	typedef struct packed {
		logic [5:0] addr;  // i/o offset
		logic wr;          // write strobe
		logic rd;          // read strobe
		logic [7:0] wdata; // write data
	} hibs_host_req_t;

	// signals from the embedded core, same clock
	typedef struct packed {
		logic irq_req;      // core raises a host interrupt (pulse)
		logic int_clear;    // core wrote one to bit 3 of its interrupt register
		logic grant;        // direct access grant bit of the core
		logic latch_strobe; // core address latch strobe
	} hibs_core_t;

	// whole state of the block
	typedef struct packed {
		logic [2:0] pnp_sync;
		logic pnp_mode;
		logic core_int;
		logic int2core;
		logic fwd_en;
		logic latch_flag;
		logic flash_sel;
		logic [1:0] mem_bank;
		logic exp_win;
		logic [1:0] xcvr_bank;
		logic [7:0] rdata;
		logic xcvr_sel;
		logic [4:0] xcvr_index;
		logic mem_flash;
		logic mem_sram;
		logic [16:0] mem_addr;
	} hibs_state_t;

endpackage : hibs_pkg

// ### verilog/hibs_regs.sv
/*
 * host interrupt status/control and bank switching select registers,
 * with the transceiver window decode and memory steering they drive.
 * assumes: host strobes and core signals are on sys_clk_in; the isa mode
 * strap is a pin and is synchronised here.
 */
`timescale 1ns/1ps
`include "hibs_defs.svh"

module hibs_regs (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// host i/o register port
	input hibs_pkg::hibs_host_req_t host_req_in,
	output logic [7:0] host_rdata_out,
	// host common memory access
	input wire logic host_mem_req_in,
	input wire logic [14:0] host_mem_addr_in,
	// embedded core side
	input hibs_pkg::hibs_core_t core_in,
	// isa plug and play strap pin
	input wire logic isa_pnp_strap_in,
	// interrupts
	output logic interrupt_to_core_out,
	output logic host_irq_out,
	// memory steering
	output logic flash_sel_out,
	output logic sram_sel_out,
	output logic [16:0] local_memory_address_out,
	// transceiver register access
	output logic xcvr_sel_out,
	output logic [4:0] xcvr_index_out
);
	import hibs_pkg::*;

	// ********************************************
	// state and decode helpers
	// ********************************************
	hibs_state_t s_ff;  // registered state
	hibs_state_t nxt_s; // next state

	// does the offset fall in the transceiver window
	function automatic logic xcvr_hit(input logic [5:0] addr, input logic exp);
		logic [5:0] hi;
		hi = exp ? `HIBS_XWIN_WIDE_HI : `HIBS_XWIN_NARROW_HI;
		xcvr_hit = (addr >= `HIBS_XWIN_LO) && (addr <= hi);
	endfunction : xcvr_hit

	// transceiver register index for an offset in the window
	function automatic logic [4:0] xcvr_idx(input logic [5:0] addr, input logic exp,
		input logic [1:0] bank);
		logic [5:0] diff;
		diff = addr - `HIBS_XWIN_LO;
		if (exp) begin
			xcvr_idx = diff[4:0];
		end else begin
			xcvr_idx = {bank, addr[2:0]};
		end
	endfunction : xcvr_idx

	logic wr_status; // host write to the status/control register
	logic wr_bank;   // host write to the bank select register
	logic rd_status; // host read of the status/control register
	logic rd_bank;   // host read of the bank select register
	logic access;    // any host i/o strobe

	// address decode
	always_comb begin
		wr_status = 1'b0;
		wr_bank = 1'b0;
		rd_status = 1'b0;
		rd_bank = 1'b0;
		access = host_req_in.wr | host_req_in.rd;
		if (host_req_in.addr == `HIBS_OFS_STATUS) begin
			wr_status = host_req_in.wr;
			rd_status = host_req_in.rd;
		end else if (host_req_in.addr == `HIBS_OFS_BANK) begin
			wr_bank = host_req_in.wr;
			rd_bank = host_req_in.rd;
		end
	end

	// ********************************************
	// next state
	// ********************************************
	always_comb begin
		nxt_s = s_ff;
		// strap synchroniser; mode changes once stages 2 and 3 agree
		nxt_s.pnp_sync = {s_ff.pnp_sync[1:0], isa_pnp_strap_in};
		if (s_ff.pnp_sync[1] == s_ff.pnp_sync[2]) begin
			nxt_s.pnp_mode = s_ff.pnp_sync[2];
		end

		// core interrupt status: host one clears, forwarded event sets, set wins
		if (wr_status && host_req_in.wdata[`HIBS_ST_CORE_INT]) begin
			nxt_s.core_int = 1'b0;
		end
		if (s_ff.fwd_en && core_in.irq_req) begin
			nxt_s.core_int = 1'b1;
		end

		// interrupt to core: core clears, host one sets, a zero does nothing
		if (core_in.int_clear) begin
			nxt_s.int2core = 1'b0;
		end
		if (wr_status && host_req_in.wdata[`HIBS_ST_INT2CORE]) begin
			nxt_s.int2core = 1'b1;
		end

		// plain control bit of the status register
		if (wr_status) begin
			nxt_s.fwd_en = host_req_in.wdata[`HIBS_ST_FWD_EN];
		end

		// bank select fields
		if (wr_bank) begin
			if (!host_req_in.wdata[`HIBS_BK_LATCH]) begin
				nxt_s.latch_flag = 1'b0;
			end
			nxt_s.flash_sel = host_req_in.wdata[`HIBS_BK_FLASH];
			nxt_s.mem_bank = host_req_in.wdata[`HIBS_BK_MBANK_HI:`HIBS_BK_MBANK_LO];
			nxt_s.exp_win = host_req_in.wdata[`HIBS_BK_EXPWIN];
			nxt_s.xcvr_bank = host_req_in.wdata[`HIBS_BK_TBANK_HI:`HIBS_BK_TBANK_LO];
		end
		// strobe sets the test flag; set wins over a clearing write
		if (core_in.latch_strobe) begin
			nxt_s.latch_flag = 1'b1;
		end
		// isa mode holds the window bit at zero whatever is written
		if (s_ff.pnp_mode) begin
			nxt_s.exp_win = 1'b0;
		end

		// read data, sampled on the read strobe; unmapped offsets read zero
		nxt_s.rdata = 8'h00;
		if (rd_status) begin
			nxt_s.rdata[`HIBS_ST_CORE_INT] = s_ff.core_int;
			nxt_s.rdata[`HIBS_ST_INT2CORE] = s_ff.int2core;
			nxt_s.rdata[`HIBS_ST_FWD_EN] = s_ff.fwd_en;
			nxt_s.rdata[`HIBS_ST_DIRECT] = core_in.grant;
		end else if (rd_bank) begin
			nxt_s.rdata[`HIBS_BK_LATCH] = s_ff.latch_flag;
			nxt_s.rdata[`HIBS_BK_FLASH] = s_ff.flash_sel;
			nxt_s.rdata[`HIBS_BK_MBANK_HI:`HIBS_BK_MBANK_LO] = s_ff.mem_bank;
			// isa mode reads zero even before the lock has cleared the stored bit
			nxt_s.rdata[`HIBS_BK_EXPWIN] = s_ff.exp_win && !s_ff.pnp_mode;
			nxt_s.rdata[`HIBS_BK_TBANK_HI:`HIBS_BK_TBANK_LO] = s_ff.xcvr_bank;
		end

		// transceiver window decode, one-cycle select pulse
		nxt_s.xcvr_sel = access && xcvr_hit(host_req_in.addr, s_ff.exp_win);
		nxt_s.xcvr_index = 5'h00;
		if (nxt_s.xcvr_sel) begin
			nxt_s.xcvr_index = xcvr_idx(host_req_in.addr, s_ff.exp_win, s_ff.xcvr_bank);
		end

		// host common memory steering and upper address lines
		nxt_s.mem_flash = host_mem_req_in && s_ff.flash_sel;
		nxt_s.mem_sram = host_mem_req_in && !s_ff.flash_sel;
		if (host_mem_req_in) begin
			nxt_s.mem_addr = {s_ff.mem_bank, host_mem_addr_in};
		end
	end

	// ********************************************
	// state register
	// ********************************************
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// outputs, all straight from the state register
	assign host_rdata_out = s_ff.rdata;
	assign interrupt_to_core_out = s_ff.int2core;
	assign host_irq_out = s_ff.core_int;
	assign flash_sel_out = s_ff.mem_flash;
	assign sram_sel_out = s_ff.mem_sram;
	assign local_memory_address_out = s_ff.mem_addr;
	assign xcvr_sel_out = s_ff.xcvr_sel;
	assign xcvr_index_out = s_ff.xcvr_index;

	// ********************************************
	// assertions
	// ********************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	// a host write that clears the status bit, with no new event
	sequence host_clear_status;
		wr_status && host_req_in.wdata[`HIBS_ST_CORE_INT] && !(s_ff.fwd_en && core_in.irq_req);
	endsequence

	// a forwarded core event
	sequence fwd_event;
		s_ff.fwd_en && core_in.irq_req;
	endsequence

	// a host write that clears the latch test flag, with no strobe beside it
	sequence host_clear_latch;
		wr_bank && !host_req_in.wdata[`HIBS_BK_LATCH] && !core_in.latch_strobe;
	endsequence

	status_hold_a: assert property (
		host_irq_out && !(wr_status && host_req_in.wdata[`HIBS_ST_CORE_INT]) |=> host_irq_out)
		else $error("status bit dropped without a host clear");
	status_clear_a: assert property (host_clear_status |=> !host_irq_out)
		else $error("host one write did not clear status");
	int_raise_a: assert property (
		wr_status && host_req_in.wdata[`HIBS_ST_INT2CORE] |=> interrupt_to_core_out)
		else $error("host one write did not raise core interrupt");
	int_keep_a: assert property (
		interrupt_to_core_out && !core_in.int_clear |=> interrupt_to_core_out)
		else $error("core interrupt dropped without core clear");
	fwd_event_a: assert property (fwd_event |=> host_irq_out ##1 host_irq_out || $past(wr_status))
		else $error("forwarded event not shown to host");
	fwd_block_a: assert property (!s_ff.fwd_en && !host_irq_out |=> !host_irq_out)
		else $error("status set while forwarding disabled");
	grant_read_a: assert property (
		rd_status |=> host_rdata_out[`HIBS_ST_DIRECT] == $past(core_in.grant))
		else $error("direct access indicator differs from grant");
	latch_flag_a: assert property (
		core_in.latch_strobe |=> s_ff.latch_flag)
		else $error("latch strobe did not set test flag");
	flash_route_a: assert property (
		host_mem_req_in |=> flash_sel_out == $past(s_ff.flash_sel) && sram_sel_out != flash_sel_out)
		else $error("memory access steered wrongly");
	bank_lines_a: assert property (
		host_mem_req_in |=> local_memory_address_out[16:15] == $past(s_ff.mem_bank))
		else $error("bank bits not on top address lines");
	narrow_win_a: assert property (
		access && !s_ff.exp_win && host_req_in.addr >= 6'h08 && host_req_in.addr <= 6'h0f
		|=> xcvr_sel_out && xcvr_index_out == {$past(s_ff.xcvr_bank), $past(host_req_in.addr[2:0])})
		else $error("narrow window index wrong");
	narrow_edge_a: assert property (
		access && !s_ff.exp_win && host_req_in.addr > 6'h0f |=> !xcvr_sel_out)
		else $error("narrow window reached past its end");
	wide_win_a: assert property (
		access && s_ff.exp_win && host_req_in.addr >= 6'h08 && host_req_in.addr <= 6'h27
		|=> xcvr_sel_out && xcvr_index_out == 5'($past(host_req_in.addr) - 6'h08))
		else $error("expanded window index wrong");
	pnp_lock_a: assert property (s_ff.pnp_mode |=> !s_ff.exp_win)
		else $error("window bit set in isa mode");

	// ********************************************
	// further checks of clears, holds, window ends, isa reads and memory lines
	// ********************************************

	// a zero write to the latch bit clears the flag unless a strobe comes with it
	latch_clear_a: assert property (host_clear_latch |=> !s_ff.latch_flag)
		else $error("zero write did not clear latch test flag");

	// without a clearing write the flag stays set
	latch_hold_a: assert property (
		s_ff.latch_flag && !(wr_bank && !host_req_in.wdata[`HIBS_BK_LATCH])
		|=> s_ff.latch_flag)
		else $error("latch test flag dropped on its own");

	// the core clear drops the interrupt unless the host sets it again
	int_clear_a: assert property (
		core_in.int_clear && !(wr_status && host_req_in.wdata[`HIBS_ST_INT2CORE])
		|=> !interrupt_to_core_out)
		else $error("core clear did not drop core interrupt");

	// a zero in the interrupt bit never raises it
	int_zero_a: assert property (
		!interrupt_to_core_out && !(wr_status && host_req_in.wdata[`HIBS_ST_INT2CORE])
		|=> !interrupt_to_core_out)
		else $error("core interrupt raised without a one write");

	// a read in isa mode never shows the window bit
	pnp_read_a: assert property (
		s_ff.pnp_mode && rd_bank |=> !host_rdata_out[`HIBS_BK_EXPWIN])
		else $error("window bit read as one in isa mode");

	// offsets past the expanded window reach no transceiver register
	wide_edge_a: assert property (
		access && s_ff.exp_win && host_req_in.addr > `HIBS_XWIN_WIDE_HI |=> !xcvr_sel_out)
		else $error("expanded window reached past its end");

	// no memory select without a host memory access
	mem_idle_a: assert property (!host_mem_req_in |=> !flash_sel_out && !sram_sel_out)
		else $error("memory select without an access");

	// the low address lines carry the host address unchanged
	low_lines_a: assert property (
		host_mem_req_in |=> local_memory_address_out[14:0] == $past(host_mem_addr_in))
		else $error("host address not on low address lines");

endmodule : hibs_regs
